// File: design/lenc_pkg.sv
// Shared types and constants for the transmit line encoder
package lenc_pkg;

	// Line rate selection
	typedef enum logic [1:0] {
		RATE_DS3 = 2'h0,
		RATE_STS1 = 2'h1,
		RATE_E3 = 2'h2
	} lenc_rate_e;

	// One line symbol: positive and negative rail
	typedef struct packed {
		logic pos;
		logic neg;
	} lenc_sym_s;

	// Start-up sequencer states
	typedef enum logic [0:0] {
		ST_FILL = 1'h0,
		ST_RUN = 1'h1
	} lenc_state_e;

	localparam int unsigned SYM_W = 2;
	// Zero-run lengths that trigger a substitution
	localparam logic [2:0] B3ZS_RUN = 3'h3;
	localparam logic [2:0] HDB3_RUN = 3'h4;
	// Symbol delay line depth, enough for the longer substitution
	localparam int unsigned DELAY_BITS = 4;
	// Output delay index of the emitted stage
	localparam int unsigned OUT_STAGE = 3;
	// FIFO depth in bits of line data
	localparam int unsigned FIFO_DEPTH = 16;
	// Line clock edges held back after reset before output starts
	localparam logic [3:0] START_FILL = 4'h4;
	// Reset values of encoder state
	localparam logic [2:0] ZCNT_RST = 3'h0;
	localparam logic LAST_NEG_RST = 1'h1;
	localparam logic PAR_RST = 1'h0;

endpackage : lenc_pkg

// File: design/lenc_encoder.sv
// Transmit B3ZS/HDB3 line encoder with input FIFO

// Synchronous FIFO with valid/ready on both sides
module lenc_fifo #(
	parameter int unsigned WIDTH = lenc_pkg::SYM_W,
	parameter int unsigned DEPTH = lenc_pkg::FIFO_DEPTH
) (
	input wire logic i_clk, // Core clock
	input wire logic i_rst_n, // Synchronised reset, active low
	input wire logic i_ce, // Clock enable
	input wire logic i_in_valid, // Write request
	output logic o_in_ready, // Space available
	input wire logic [WIDTH-1:0] i_in_data, // Write data
	output logic o_out_valid, // Data available
	input wire logic i_out_ready, // Read request
	output logic [WIDTH-1:0] o_out_data // Read data
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;

	// Handshake decode
	wire do_wr = i_ce && i_in_valid && o_in_ready;
	wire do_rd = i_ce && o_out_valid && i_out_ready;
	assign o_in_ready = (count_r != FULL);
	assign o_out_valid = (count_r != '0);
	assign o_out_data = mem_r[rd_ptr_r];

	// Pointer wrap, depth need not be a power of two
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == LAST) ? '0 : p + 1'b1;
	endfunction : bump

	// Storage, no reset needed on the data itself
	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_r <= bump(wr_ptr_r);
			end
			if (do_rd) begin
				rd_ptr_r <= bump(rd_ptr_r);
			end
			if (do_wr && !do_rd) begin
				count_r <= count_r + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule : lenc_fifo

// Encoder top: samples line data, buffers it, codes it, drives rails
module lenc_encoder #(
	parameter int unsigned FIFO_DEPTH = lenc_pkg::FIFO_DEPTH
) (
	input wire logic i_clk, // Core clock, 250 MHz
	input wire logic i_nrst, // Async reset, active low
	input wire logic i_ce, // Clock enable, freezes all state but the reset synchroniser when low
	input wire logic i_tx_line_clock, // Transmit line clock, sampled as data
	input wire logic i_tx_positive_rail, // NRZ data or positive rail
	input wire logic i_tx_negative_rail, // Negative rail, dual-rail only
	input wire lenc_pkg::lenc_rate_e i_rate, // Line rate select
	input wire logic i_dual_rail, // 1: dual-rail input, encoder bypassed
	input wire logic i_sample_falling, // 1: sample on falling line clock edge
	input wire logic i_build_out_disable, // 1: build-out stage off
	output logic o_tx_positive_rail, // Coded positive rail
	output logic o_tx_negative_rail, // Coded negative rail
	output logic o_build_out_enable, // Build-out stage enable
	output logic o_in_ready, // FIFO has room for the next bit
	output logic o_running // Start-up delay done, output live
);

	// Reset synchroniser
	logic rst_meta_r;
	logic rst_n;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// Builds a single pulse of the given polarity
	function automatic lenc_pkg::lenc_sym_s pulse(input logic neg);
		pulse.pos = ~neg;
		pulse.neg = neg;
	endfunction : pulse

	logic line_clk_prev_r;
	logic run_r;
	lenc_pkg::lenc_state_e state_r;
	logic [3:0] fill_cnt_r;
	logic [2:0] zcnt_r;
	logic last_neg_r;
	logic par_r;
	lenc_pkg::lenc_sym_s dly_r [0:lenc_pkg::DELAY_BITS-1];
	lenc_pkg::lenc_sym_s dly_nxt [0:lenc_pkg::DELAY_BITS-1];
	lenc_pkg::lenc_sym_s dly_sh [0:lenc_pkg::DELAY_BITS-1];
	logic pos_r;
	logic neg_r;
	logic bo_en_r;
	logic in_ready_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	lenc_pkg::lenc_sym_s fifo_out_data;

	// Line clock edge detect; one selected edge is one bit time
	wire line_rise = i_tx_line_clock && !line_clk_prev_r;
	wire line_fall = !i_tx_line_clock && line_clk_prev_r;
	wire tick = i_ce && (i_sample_falling ? line_fall : line_rise);
	wire running = (state_r == lenc_pkg::ST_RUN);
	wire advance = tick && running;

	// Sampled input word; negative rail only matters in dual-rail
	lenc_pkg::lenc_sym_s in_sym;
	assign in_sym.pos = i_tx_positive_rail;
	assign in_sym.neg = i_dual_rail ? i_tx_negative_rail : 1'b0;

	// Buffer sits ahead of the coder; its fill is the start-up latency
	lenc_fifo #(
		.WIDTH(lenc_pkg::SYM_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_in_valid(tick),
		.o_in_ready(fifo_in_ready),
		.i_in_data(in_sym),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(advance),
		.o_out_data(fifo_out_data)
	);

	// An empty FIFO is coded as zeros so the line never stalls
	lenc_pkg::lenc_sym_s cur;
	assign cur = fifo_out_valid ? fifo_out_data : '0;
	wire bit_one = cur.pos;

	// Substitution decode
	wire [2:0] run_len = (i_rate == lenc_pkg::RATE_E3) ? lenc_pkg::HDB3_RUN
		: lenc_pkg::B3ZS_RUN;
	wire [2:0] zcnt_inc = zcnt_r + 3'h1;
	wire subst = !i_dual_rail && !bit_one && (zcnt_inc == run_len);
	// Even pulse count since last V needs a B to make it odd
	wire use_b = subst && !par_r;
	wire mark_neg = ~last_neg_r;
	wire v_neg = use_b ? mark_neg : last_neg_r;

	// Symbol entering the delay line
	lenc_pkg::lenc_sym_s new_sym;
	assign new_sym = i_dual_rail ? cur
		: bit_one ? pulse(mark_neg)
		: subst ? pulse(v_neg)
		: '0;

	// Delay line shift, B written back over the first zero of the run
	assign dly_sh[0] = new_sym;
	for (genvar i = 0; i < lenc_pkg::DELAY_BITS; i++) begin : g_dly
		if (i > 0) begin : g_sh
			assign dly_sh[i] = dly_r[i-1];
		end
		assign dly_nxt[i] = (use_b && (run_len == 3'(i + 1))) ? pulse(mark_neg)
			: dly_sh[i];
	end

	// Next coder state
	wire [2:0] zcnt_nxt = (i_dual_rail || bit_one || subst) ? lenc_pkg::ZCNT_RST
		: zcnt_inc;
	wire last_neg_nxt = i_dual_rail ? last_neg_r
		: bit_one ? mark_neg
		: subst ? v_neg
		: last_neg_r;
	// Parity counts marks only; a V restarts it
	wire par_nxt = i_dual_rail ? par_r
		: bit_one ? ~par_r
		: subst ? lenc_pkg::PAR_RST
		: par_r;

	// Start-up sequencer
	wire fill_done = (fill_cnt_r == lenc_pkg::START_FILL - 4'h1);
	lenc_pkg::lenc_state_e state_nxt;
	always_comb begin
		case (state_r)
			lenc_pkg::ST_FILL: state_nxt = (tick && fill_done) ? lenc_pkg::ST_RUN
				: lenc_pkg::ST_FILL;
			lenc_pkg::ST_RUN: state_nxt = lenc_pkg::ST_RUN;
			default: state_nxt = lenc_pkg::ST_FILL;
		endcase
	end

	// Edge history and sequencer
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_clk_prev_r <= 1'b0;
			state_r <= lenc_pkg::ST_FILL;
			run_r <= 1'b0;
			fill_cnt_r <= 4'h0;
		end else if (i_ce) begin
			line_clk_prev_r <= i_tx_line_clock;
			state_r <= state_nxt;
			// Output copy of the state so the pin comes from a flop
			run_r <= (state_nxt == lenc_pkg::ST_RUN);
			if (tick && !running) begin
				fill_cnt_r <= fill_cnt_r + 4'h1;
			end
		end
	end

	// Coder state, cleared at reset except last_neg_r, which resets to 1
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			zcnt_r <= lenc_pkg::ZCNT_RST;
			last_neg_r <= lenc_pkg::LAST_NEG_RST;
			par_r <= lenc_pkg::PAR_RST;
		end else if (advance) begin
			zcnt_r <= zcnt_nxt;
			last_neg_r <= last_neg_nxt;
			par_r <= par_nxt;
		end
	end

	// Delay line, the oldest stage feeds the rails
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < lenc_pkg::DELAY_BITS; i++) begin
				dly_r[i] <= '0;
			end
		end else if (advance) begin
			for (int i = 0; i < lenc_pkg::DELAY_BITS; i++) begin
				dly_r[i] <= dly_nxt[i];
			end
		end
	end

	// Output rails; stage taken after write-back so a B is never missed
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_r <= 1'b0;
			neg_r <= 1'b0;
		end else if (advance) begin
			pos_r <= dly_nxt[lenc_pkg::OUT_STAGE].pos;
			neg_r <= dly_nxt[lenc_pkg::OUT_STAGE].neg;
		end
	end

	// Build-out control; E3 overrides software
	wire bo_en_nxt = (i_rate != lenc_pkg::RATE_E3) && !i_build_out_disable;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			bo_en_r <= 1'b0;
			in_ready_r <= 1'b0;
		end else if (i_ce) begin
			bo_en_r <= bo_en_nxt;
			in_ready_r <= fifo_in_ready;
		end
	end

	assign o_tx_positive_rail = pos_r;
	assign o_tx_negative_rail = neg_r;
	assign o_build_out_enable = bo_en_r;
	assign o_in_ready = in_ready_r;
	assign o_running = run_r;

endmodule : lenc_encoder

// File: verif/lenc_encoder_props.sv
// Port checker for the transmit line encoder
module lenc_encoder_props (
	input wire logic i_clk, // Clock
	input wire logic i_nrst, // Reset
	input wire logic i_ce, // Enable
	input wire logic i_tx_line_clock, // Line clock
	input wire logic i_tx_positive_rail, // Data
	input wire logic i_tx_negative_rail, // Neg data
	input wire lenc_pkg::lenc_rate_e i_rate, // Rate
	input wire logic i_dual_rail, // Bypass
	input wire logic i_sample_falling, // Edge
	input wire logic i_build_out_disable, // Build-out off
	input wire logic o_tx_positive_rail, // Pos out
	input wire logic o_tx_negative_rail, // Neg out
	input wire logic o_build_out_enable, // Build-out
	input wire logic o_in_ready, // Ready
	input wire logic o_running // Running
);
	logic lp_r, pv_r;
	logic [3:0] tk_r, zc_r, ag_r;
	wire tk = (i_tx_line_clock != lp_r) && (i_tx_line_clock == !i_sample_falling);
	wire [1:0] rails = {o_tx_positive_rail, o_tx_negative_rail};
	wire e3 = (i_rate == lenc_pkg::RATE_E3);
	// Zero runs only counted well after start, the delay line fills with plain zeros
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lp_r <= 1'b0;
			pv_r <= 1'b0;
			tk_r <= 4'h0;
			zc_r <= 4'h0;
			ag_r <= 4'h0;
		end else begin
			lp_r <= i_tx_line_clock;
			pv_r <= pv_r | (rails != 2'h0);
			ag_r <= (ag_r == 4'h4) ? ag_r : ag_r + 4'h1;
			tk_r <= (tk && tk_r != 4'hf) ? tk_r + 4'h1 : tk_r;
			if (tk && tk_r == 4'hf) begin
				zc_r <= (rails == 2'h0) ? zc_r + 4'h1 : 4'h0;
			end
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	a_rails_exclusive: assert property (!i_dual_rail |-> rails != 2'h3)
		else $error("both rails high");
	a_quiet_before_run: assert property (!o_running |-> rails == 2'h0)
		else $error("rails active before start");
	a_build_follows: assert property (ag_r == 4'h4 && i_ce
		|=> o_build_out_enable == $past(!e3 && !i_build_out_disable)) else $error("build-out");
	a_e3_no_build: assert property (e3 |=> !o_build_out_enable)
		else $error("build-out on at E3");
	a_rails_on_tick: assert property ($changed(rails) |-> $past(tk) || $past(tk, 2))
		else $error("rails moved off a bit edge");
	a_fill_count: assert property ($rose(o_running) |-> tk_r >= lenc_pkg::START_FILL
		&& tk_r <= lenc_pkg::START_FILL + 4'h2) else $error("start delay wrong");
	a_first_pos: assert property (!pv_r && rails != 2'h0 && !i_dual_rail
		|-> o_tx_positive_rail) else $error("first pulse not positive");
	a_zero_run: assert property (tk_r == 4'hf && !i_dual_rail
		|-> zc_r <= (e3 ? 4'h3 : 4'h2)) else $error("zero run too long");
	a_ready_running: assert property (o_running |-> o_in_ready)
		else $error("buffer full while running");
	c_run: cover property ($rose(o_running));
	c_e3_tick: cover property (e3 && tk && o_running);
	c_dual_both: cover property (i_dual_rail && rails == 2'h3);
endmodule : lenc_encoder_props
bind lenc_encoder lenc_encoder_props u_lenc_encoder_props (.*);

// File: verif/lenc_framer_model.sv
// Behavioural framer feeding line clock and data
module lenc_framer_model (
	input wire logic i_clk, // Core clock
	input wire logic i_fall, // Falling edge selected
	output logic o_line_clock, // Line clock
	output logic o_pos, // NRZ data or positive rail
	output logic o_neg // Negative rail
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_line_clock = 1'b0;
		o_pos = 1'b0;
		o_neg = 1'b1;
	end
	// Idle opposite the selected edge so the first bit is a clean edge
	task automatic park();
		o_line_clock = i_fall;
	endtask : park
	// One bit per period of 2*h core cycles; data moves only with the selected edge
	task automatic send(input logic p, input logic n, input logic d, input int h);
		#1;
		o_line_clock = !i_fall;
		o_pos = p;
		o_neg = d ? n : !o_neg;
		repeat (h) @(posedge i_clk);
		#1;
		o_line_clock = i_fall;
		repeat (h) @(posedge i_clk);
	endtask : send
endmodule : lenc_framer_model

// File: verif/tb_top.sv
// Self-checking bench for the transmit line encoder
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int N = 64;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic fall = 1'b0;
	logic dual = 1'b0;
	logic bod = 1'b0;
	lenc_pkg::lenc_rate_e rate = lenc_pkg::RATE_DS3;
	logic lc, dp, dn, o_p, o_n, o_run, o_bo, mp;
	logic bits[N];
	logic negs[N];
	lenc_pkg::lenc_sym_s sym[N];
	lenc_pkg::lenc_sym_s exp_q[$];
	int mismatches = 0;
	int cmp_count = 0;
	int ticks = 0;
	always #2 i_clk = ~i_clk;
	lenc_encoder u_lenc_encoder (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
		.i_tx_line_clock(lc), .i_tx_positive_rail(dp), .i_tx_negative_rail(dn),
		.i_rate(rate), .i_dual_rail(dual), .i_sample_falling(fall),
		.i_build_out_disable(bod), .o_tx_positive_rail(o_p), .o_tx_negative_rail(o_n),
		.o_build_out_enable(o_bo), .o_in_ready(), .o_running(o_run));
	lenc_framer_model u_lenc_framer_model (.i_clk(i_clk), .i_fall(fall), .o_line_clock(lc),
		.o_pos(dp), .o_neg(dn));
	task automatic check(input lenc_pkg::lenc_sym_s seen, input lenc_pkg::lenc_sym_s want);
		cmp_count++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t rails %b want %b", $time, seen, want);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	// Own coder: last pulse starts negative, pulse count starts even
	task automatic encode(input int run, input logic d);
		logic pol;
		logic odd;
		int zc;
		pol = 1'b0;
		odd = 1'b0;
		zc = 0;
		for (int i = 0; i < N; i++) begin
			zc = bits[i] ? 0 : zc + 1;
			sym[i] = {bits[i], negs[i]};
			if (!d) begin
				sym[i] = 2'h0;
				if (bits[i]) begin
					pol = !pol;
					odd = !odd;
				end else if (zc == run) begin
					if (!odd) begin
						pol = !pol;
						sym[i - run + 1] = {pol, !pol};
					end
					odd = 1'b0;
					zc = 0;
				end
				if (bits[i] || zc == 0) sym[i] = {pol, !pol};
			end
		end
	endtask : encode
	// Reset, then one random burst opening on a zero run straight after reset
	task automatic run_case(input lenc_pkg::lenc_rate_e r, input logic f, input logic d);
		@(posedge i_clk);
		#1;
		i_nrst = 1'b0;
		rate = r;
		fall = f;
		dual = d;
		ticks = 0;
		u_lenc_framer_model.park();
		for (int i = 0; i < N; i++) begin
			bits[i] = (i > 3) && ($urandom % 3 == 0);
			negs[i] = 1'($urandom);
		end
		encode((r == lenc_pkg::RATE_E3) ? 4 : 3, d);
		for (int i = 0; i < N - 8; i++) exp_q.push_back(sym[i]);
		repeat (3) @(posedge i_clk);
		#1;
		i_nrst = 1'b1;
		repeat (4) @(posedge i_clk);
		for (int i = 0; i < N; i++) begin
			bod <= 1'($urandom);
			u_lenc_framer_model.send(bits[i], negs[i], d, 2 + $urandom % 2);
		end
		check({o_run, exp_q.size() == 0}, 2'h3);
		// Build-out control has been steady for a whole bit time here
		check({o_bo, 1'b0}, {(r != lenc_pkg::RATE_E3) && !bod, 1'b0});
	endtask : run_case
	// At each selected line edge the rails still show the bit from eight edges back
	always @(posedge i_clk) begin
		if (lc != mp && lc == !fall) begin
			if (ticks >= 8 && exp_q.size() > 0) check({o_p, o_n}, exp_q.pop_front());
			ticks++;
		end
		mp = lc;
	end
	initial begin
		void'($urandom(9));
		run_case(lenc_pkg::RATE_DS3, 1'b0, 1'b0);
		run_case(lenc_pkg::RATE_E3, 1'b1, 1'b0);
		run_case(lenc_pkg::RATE_STS1, 1'b0, 1'b0);
		run_case(lenc_pkg::RATE_E3, 1'b1, 1'b1);
		tally_and_finish();
	end
	// Four bursts need about 1300 cycles; a hang is cut off well beyond that
	initial begin
		#60000;
		mismatches++;
		tally_and_finish();
	end
endmodule : tb_top
